// ### vscf_sequencer.sv
// Sequencer clocking, plane write mask and font select register bank
`timescale 1ns/100ps

// What this block does
// - Quad-load bit loads shifters every fourth character
// - Half-load bit: every character or every other
// - Dot divide bit halves the pixel clock
// - Width bit picks nine or eight dots
// - Nine-dot disable forces eight-dot characters
// - Panning follows the written width bit
// - Reserved bits read back as zero
// - Mask bits enable processor writes per plane
// - Mask still gates under odd/even, chain-4
// - Differing fonts: attribute bit 3 picks font
// - Without extended memory only maps 0, 4
// - Primary map from bits 1:0 and 4
module vscf_sequencer
  import vscf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sequencer index and data ports
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Separate width override
  input wire logic nine_dot_disable,
  // Display timing
  output logic pixel_en,
  output logic char_clk,
  output logic shift_load,
  output logic wide_char,
  output logic screen_off,
  // Processor plane writes
  input wire logic cpu_wr,
  input wire logic [3:0] cpu_plane_sel,
  output logic [3:0] plane_wr_en,
  output logic odd_even_mode,
  output logic chain4_mode,
  // Text attribute and fonts
  input wire logic attr_bit3,
  output logic [2:0] font_a_map,
  output logic [2:0] font_b_map,
  output logic [15:0] glyph_base,
  output logic fg_intense,
  // Horizontal panning
  input wire logic [3:0] pan_value,
  output logic [3:0] pan_shift
);
  vscf_ctl_if ctl_bus ();

  // Register state
  logic [2:0] idx_q, idx_d;
  logic [7:0] clocking_q, clocking_d;
  logic [7:0] plane_mask_q, plane_mask_d;
  logic [7:0] font_q, font_d;
  logic [7:0] layout_q, layout_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] reg_view;
  logic idx_hit, data_hit;

  // Datapath state
  logic [3:0] plane_q, plane_d;
  logic [3:0] pan_q, pan_d;
  logic oe_q, oe_d;
  logic c4_q, c4_d;

  // Index decode for the read path; the write path decodes idx_q in its own case
  function automatic logic [7:0] read_reg(
    input logic [2:0] idx,
    input logic [7:0] clk_r,
    input logic [7:0] msk_r,
    input logic [7:0] fnt_r,
    input logic [7:0] mem_r
  );
    case (idx)
      IDX_CLOCKING: read_reg = clk_r & MASK_CLOCKING;
      IDX_PLANE_MASK: read_reg = msk_r & MASK_PLANE;
      IDX_FONT_SEL: read_reg = fnt_r & MASK_FONT;
      IDX_MEM_LAYOUT: read_reg = mem_r & MASK_MEM_LAYOUT;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // Address decode of the two I/O ports
  always_comb begin
    idx_hit = (io_addr == IO_SEQ_INDEX);
    data_hit = (io_addr == IO_SEQ_DATA);
    reg_view = read_reg(idx_q, clocking_q, plane_mask_q, font_q, layout_q);
  end

  // Register writes and read data
  always_comb begin
    idx_d = idx_q;
    clocking_d = clocking_q;
    plane_mask_d = plane_mask_q;
    font_d = font_q;
    layout_d = layout_q;
    rdata_d = rdata_q;
    if (io_wr && idx_hit) begin
      idx_d = io_wdata[2:0];
    end
    if (io_wr && data_hit) begin
      case (idx_q)
        IDX_CLOCKING: clocking_d = io_wdata & MASK_CLOCKING;
        IDX_PLANE_MASK: plane_mask_d = io_wdata & MASK_PLANE;
        IDX_FONT_SEL: font_d = io_wdata & MASK_FONT;
        IDX_MEM_LAYOUT: layout_d = io_wdata & MASK_MEM_LAYOUT;
        default: idx_d = idx_q;
      endcase
    end
    // Reads of any other address return zero rather than holding stale data
    if (io_rd) begin
      if (idx_hit) begin
        rdata_d = {5'h00, idx_q};
      end else if (data_hit) begin
        rdata_d = reg_view;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      idx_q <= RST_INDEX;
      clocking_q <= RST_CLOCKING;
      plane_mask_q <= RST_PLANE_MASK;
      font_q <= RST_FONT_SEL;
      layout_q <= RST_MEM_LAYOUT;
      rdata_q <= 8'h00;
    end else begin
      idx_q <= idx_d;
      clocking_q <= clocking_d;
      plane_mask_q <= plane_mask_d;
      font_q <= font_d;
      layout_q <= layout_d;
      rdata_q <= rdata_d;
    end
  end

  // Settings handed to the timing and font logic
  assign ctl_bus.dot_div = clocking_q[CLK_DOT_DIV];
  assign ctl_bus.half_load = clocking_q[CLK_HALF_LOAD];
  assign ctl_bus.quad_load = clocking_q[CLK_QUAD_LOAD];
  assign ctl_bus.eight_dot = clocking_q[CLK_EIGHT_DOT];
  assign ctl_bus.nine_dot_off = nine_dot_disable;
  assign ctl_bus.font_sel = font_q[5:0];
  assign ctl_bus.ext_mem = layout_q[MEM_EXT];
  assign ctl_bus.attr_bit3 = attr_bit3;

  vscf_char_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .ctl(ctl_bus)
  );

  vscf_font_sel u_font (
    .clk(clk),
    .resetn(resetn),
    .ctl(ctl_bus)
  );

  // Plane write gating and panning
  always_comb begin
    // Mask applies after addressing picks planes, whatever the addressing mode
    plane_d = cpu_wr ? (cpu_plane_sel & plane_mask_q[3:0]) : 4'h0;
    oe_d = layout_q[MEM_ODD_EVEN] & ~layout_q[MEM_CHAIN4];
    c4_d = layout_q[MEM_CHAIN4];
    // Panning uses the written width bit, not the override
    if (clocking_q[CLK_EIGHT_DOT]) begin
      pan_d = {1'b0, pan_value[2:0]};
    end else if (pan_value >= DOTS_NARROW) begin
      pan_d = 4'h0;
    end else begin
      pan_d = pan_value + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      plane_q <= 4'h0;
      pan_q <= 4'h0;
      oe_q <= 1'b0;
      c4_q <= 1'b0;
    end else begin
      plane_q <= plane_d;
      pan_q <= pan_d;
      oe_q <= oe_d;
      c4_q <= c4_d;
    end
  end

  // Outputs
  assign io_rdata = rdata_q;
  assign pixel_en = ctl_bus.pixel_en;
  assign char_clk = ctl_bus.char_clk;
  assign shift_load = ctl_bus.shift_load;
  assign wide_char = ctl_bus.wide_char;
  assign screen_off = clocking_q[CLK_SCREEN_OFF];
  assign plane_wr_en = plane_q;
  assign odd_even_mode = oe_q;
  assign chain4_mode = c4_q;
  assign font_a_map = ctl_bus.font_a_map;
  assign font_b_map = ctl_bus.font_b_map;
  assign glyph_base = ctl_bus.glyph_base;
  assign fg_intense = ctl_bus.fg_intense;
  assign pan_shift = pan_q;
endmodule : vscf_sequencer

// ### vscf_pkg.sv
// Shared constants for the sequencer clocking and font control block
package vscf_pkg;
  // I/O port addresses
  localparam logic [15:0] IO_SEQ_INDEX = 16'h03C4;
  localparam logic [15:0] IO_SEQ_DATA = 16'h03C5;
  // Register indices behind the data port
  localparam logic [2:0] IDX_CLOCKING = 3'h1;
  localparam logic [2:0] IDX_PLANE_MASK = 3'h2;
  localparam logic [2:0] IDX_FONT_SEL = 3'h3;
  localparam logic [2:0] IDX_MEM_LAYOUT = 3'h4;
  // Reset values
  localparam logic [7:0] RST_CLOCKING = 8'h00;
  localparam logic [7:0] RST_PLANE_MASK = 8'h00;
  localparam logic [7:0] RST_FONT_SEL = 8'h00;
  localparam logic [7:0] RST_MEM_LAYOUT = 8'h00;
  localparam logic [2:0] RST_INDEX = 3'h0;
  // Writable bits; all others read as zero
  localparam logic [7:0] MASK_CLOCKING = 8'h3D;
  localparam logic [7:0] MASK_PLANE = 8'h0F;
  localparam logic [7:0] MASK_FONT = 8'h3F;
  localparam logic [7:0] MASK_MEM_LAYOUT = 8'h0E;
  // Clocking register fields
  localparam int CLK_EIGHT_DOT = 0;
  localparam int CLK_HALF_LOAD = 2;
  localparam int CLK_DOT_DIV = 3;
  localparam int CLK_QUAD_LOAD = 4;
  localparam int CLK_SCREEN_OFF = 5;
  // Font select fields
  localparam int FNT_A_LO = 0;
  localparam int FNT_B_LO = 2;
  localparam int FNT_A_HI = 4;
  localparam int FNT_B_HI = 5;
  // Memory layout fields
  localparam int MEM_EXT = 1;
  localparam int MEM_ODD_EVEN = 2;
  localparam int MEM_CHAIN4 = 3;
  // Character timing
  localparam logic [3:0] DOTS_NARROW = 4'h8;
  localparam logic [3:0] DOTS_WIDE = 4'h9;
  localparam int FONT_SLOT_SHIFT = 13;
endpackage : vscf_pkg

// ### vscf_ctl_if.sv
// Links the register bank to the timing and font submodules
`timescale 1ns/100ps
interface vscf_ctl_if;
  logic dot_div;
  logic half_load;
  logic quad_load;
  logic eight_dot;
  logic nine_dot_off;
  logic pixel_en;
  logic char_clk;
  logic shift_load;
  logic wide_char;
  logic [5:0] font_sel;
  logic ext_mem;
  logic attr_bit3;
  logic [2:0] font_a_map;
  logic [2:0] font_b_map;
  logic [15:0] glyph_base;
  logic fg_intense;
  modport regs (output dot_div, half_load, quad_load, eight_dot, nine_dot_off, font_sel,
                ext_mem, attr_bit3, input pixel_en, char_clk, shift_load, wide_char,
                font_a_map, font_b_map, glyph_base, fg_intense);
  modport timer (input dot_div, half_load, quad_load, eight_dot, nine_dot_off,
                 output pixel_en, char_clk, shift_load, wide_char);
  modport font (input font_sel, ext_mem, attr_bit3,
                output font_a_map, font_b_map, glyph_base, fg_intense);
endinterface : vscf_ctl_if

// ### vscf_char_timer.sv
// Dot clock divider, character clock and shift-load cadence
`timescale 1ns/100ps
module vscf_char_timer
  import vscf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Settings in, timing out
  vscf_ctl_if.timer ctl
);
  logic phase_q, phase_d;
  logic pix_q, pix_d;
  logic [3:0] dot_q, dot_d;
  logic [1:0] lcnt_q, lcnt_d;
  logic chr_q, chr_d;
  logic ld_q, ld_d;
  logic div_q, div_d;
  logic half_q, half_d;
  logic quad_q, quad_d;
  logic eight_q, eight_d;
  logic wide_q, wide_d;
  logic last_dot;

  // Settings are sampled only at a character boundary so no cell is cut short
  always_comb begin
    last_dot = pix_q && (dot_q == ((eight_q ? DOTS_NARROW : DOTS_WIDE) - 4'h1));
    phase_d = div_q ? ~phase_q : 1'b0;
    pix_d = ~div_q | phase_q;
    dot_d = dot_q;
    lcnt_d = lcnt_q;
    chr_d = 1'b0;
    ld_d = 1'b0;
    div_d = div_q;
    half_d = half_q;
    quad_d = quad_q;
    eight_d = eight_q;
    wide_d = wide_q;
    if (pix_q) begin
      dot_d = dot_q + 4'h1;
    end
    if (last_dot) begin
      dot_d = 4'h0;
      chr_d = 1'b1;
      lcnt_d = lcnt_q + 2'h1;
      if (quad_q) begin
        ld_d = (lcnt_q == 2'h3);
      end else if (half_q) begin
        ld_d = lcnt_q[0];
      end else begin
        ld_d = 1'b1;
      end
      div_d = ctl.dot_div;
      half_d = ctl.half_load;
      quad_d = ctl.quad_load;
      eight_d = ctl.eight_dot | ctl.nine_dot_off;
      wide_d = ~(ctl.eight_dot | ctl.nine_dot_off);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_q <= 1'b0;
      pix_q <= 1'b0;
      dot_q <= 4'h0;
      lcnt_q <= 2'h0;
      chr_q <= 1'b0;
      ld_q <= 1'b0;
      div_q <= 1'b0;
      half_q <= 1'b0;
      quad_q <= 1'b0;
      eight_q <= 1'b0;
      // Own flop keeps the width flag glitch free; reset matches nine-dot default
      wide_q <= 1'b1;
    end else begin
      phase_q <= phase_d;
      pix_q <= pix_d;
      dot_q <= dot_d;
      lcnt_q <= lcnt_d;
      chr_q <= chr_d;
      ld_q <= ld_d;
      div_q <= div_d;
      half_q <= half_d;
      quad_q <= quad_d;
      eight_q <= eight_d;
      wide_q <= wide_d;
    end
  end

  assign ctl.pixel_en = pix_q;
  assign ctl.char_clk = chr_q;
  assign ctl.shift_load = ld_q;
  assign ctl.wide_char = wide_q;
endmodule : vscf_char_timer

// ### vscf_font_sel.sv
// Character map decode and attribute bit 3 steering
`timescale 1ns/100ps
module vscf_font_sel
  import vscf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Font settings in, map selection out
  vscf_ctl_if.font ctl
);
  // Slot order in plane 2 is {low pair, high bit}; map number is {high bit, low pair}
  function automatic logic [2:0] map_num(input logic [1:0] lo, input logic hi);
    map_num = {hi, lo};
  endfunction : map_num

  function automatic logic [15:0] slot_base(input logic [1:0] lo, input logic hi);
    slot_base = 16'({lo, hi}) << FONT_SLOT_SHIFT;
  endfunction : slot_base

  logic [1:0] a_lo, b_lo;
  logic [2:0] a_map_q, a_map_d, b_map_q, b_map_d;
  logic [15:0] base_q, base_d;
  logic int_q, int_d;
  logic use_b;

  always_comb begin
    // Without extended memory only maps 0 and 4 remain
    a_lo = ctl.ext_mem ? ctl.font_sel[FNT_A_LO +: 2] : 2'h0;
    b_lo = ctl.ext_mem ? ctl.font_sel[FNT_B_LO +: 2] : 2'h0;
    a_map_d = map_num(a_lo, ctl.font_sel[FNT_A_HI]);
    b_map_d = map_num(b_lo, ctl.font_sel[FNT_B_HI]);
    use_b = (a_map_d != b_map_d) && ~ctl.attr_bit3;
    base_d = use_b ? slot_base(b_lo, ctl.font_sel[FNT_B_HI])
                   : slot_base(a_lo, ctl.font_sel[FNT_A_HI]);
    int_d = (a_map_d == b_map_d) && ctl.attr_bit3;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      a_map_q <= 3'h0;
      b_map_q <= 3'h0;
      base_q <= 16'h0000;
      int_q <= 1'b0;
    end else begin
      a_map_q <= a_map_d;
      b_map_q <= b_map_d;
      base_q <= base_d;
      int_q <= int_d;
    end
  end

  assign ctl.font_a_map = a_map_q;
  assign ctl.font_b_map = b_map_q;
  assign ctl.glyph_base = base_q;
  assign ctl.fg_intense = int_q;
endmodule : vscf_font_sel

// ### vscf_seq_props.sv
// Port-level checker for the sequencer clocking and font register bank
`timescale 1ns/100ps
module vscf_seq_chk
  import vscf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Watched ports
  input wire logic pixel_en,
  input wire logic char_clk,
  input wire logic shift_load,
  input wire logic cpu_wr,
  input wire logic [3:0] cpu_plane_sel,
  input wire logic [3:0] plane_wr_en,
  input wire logic odd_even_mode,
  input wire logic chain4_mode,
  input wire logic attr_bit3,
  input wire logic [2:0] font_a_map,
  input wire logic [2:0] font_b_map,
  input wire logic fg_intense
);
  // Characters since the last shift load, saturating
  logic [2:0] since_load_q;
  logic [2:0] since_load_d;
  always_comb begin
    since_load_d = since_load_q;
    if (shift_load) since_load_d = 3'h0;
    else if (char_clk && since_load_q != 3'h7) since_load_d = since_load_q + 3'h1;
  end
  always_ff @(posedge clk) begin
    if (!resetn) since_load_q <= 3'h0;
    else since_load_q <= since_load_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_char_quiet;
    !char_clk [*7];
  endsequence
  sequence s_maps_steady;
    $stable(font_a_map) && $stable(font_b_map);
  endsequence
  a_char_min_len: assert property (char_clk |=> s_char_quiet)
    else $error("character shorter than eight clocks");
  a_char_max_len: assert property (char_clk |-> ##[8:18] char_clk)
    else $error("character longer than eighteen clocks");
  a_load_at_edge: assert property (shift_load |-> char_clk)
    else $error("shift load away from character boundary");
  a_load_cadence: assert property (since_load_q <= 3'h3)
    else $error("more than three characters without a load");
  a_plane_idle: assert property (!cpu_wr |=> plane_wr_en == 4'h0)
    else $error("plane write enable without request");
  a_plane_subset: assert property (cpu_wr |=> (plane_wr_en & ~$past(cpu_plane_sel)) == 4'h0)
    else $error("write enabled on a plane not addressed");
  a_mode_excl: assert property (chain4_mode |-> !odd_even_mode)
    else $error("odd/even flagged while chain-4 active");
  a_pixel_gap: assert property (!pixel_en |=> pixel_en)
    else $error("pixel enable low two clocks running");
  a_fg_differ: assert property (s_maps_steady and font_a_map != font_b_map |-> !fg_intense)
    else $error("intensity set while fonts differ");
  a_fg_equal: assert property (s_maps_steady and font_a_map == font_b_map |-> fg_intense == $past(attr_bit3))
    else $error("intensity not following attribute bit");
endmodule : vscf_seq_chk

bind vscf_sequencer vscf_seq_chk i_vscf_seq_chk (
  .clk(clk), .resetn(resetn), .pixel_en(pixel_en), .char_clk(char_clk),
  .shift_load(shift_load), .cpu_wr(cpu_wr), .cpu_plane_sel(cpu_plane_sel),
  .plane_wr_en(plane_wr_en), .odd_even_mode(odd_even_mode), .chain4_mode(chain4_mode),
  .attr_bit3(attr_bit3), .font_a_map(font_a_map), .font_b_map(font_b_map),
  .fg_intense(fg_intense)
);

// ### tb_vscf_sequencer.sv
// Self-checking bench for the sequencer clocking and font register bank
`timescale 1ns/100ps
module tb_vscf_sequencer
  import vscf_pkg::*;
;
  logic clk = 1'b0;
  logic resetn, io_wr, io_rd, nine_dot_disable, cpu_wr, attr_bit3;
  logic pixel_en, char_clk, shift_load, wide_char, screen_off, odd_even_mode, chain4_mode;
  logic fg_intense;
  logic [15:0] io_addr, glyph_base;
  logic [7:0] io_wdata, io_rdata;
  logic [3:0] cpu_plane_sel, pan_value, plane_wr_en, pan_shift;
  logic [2:0] font_a_map, font_b_map;
  int miscompares = 0;
  int checks = 0;
  int loads, cyc;
  logic [7:0] clk_vals [7] = '{8'h01, 8'h05, 8'h11, 8'h15, 8'h00, 8'h08, 8'h09};
  int len_exp [7] = '{8, 8, 8, 8, 9, 18, 16};
  int load_exp [7] = '{8, 4, 2, 2, 8, 8, 8};
  logic [7:0] fonts [4] = '{8'h00, 8'h12, 8'h2D, 8'h3F};
  logic [3:0] pans [4] = '{4'h3, 4'h7, 4'h9, 4'hC};

  vscf_sequencer i_vscf_sequencer (
    .clk, .resetn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .nine_dot_disable,
    .pixel_en, .char_clk, .shift_load, .wide_char, .screen_off, .cpu_wr, .cpu_plane_sel,
    .plane_wr_en, .odd_even_mode, .chain4_mode, .attr_bit3, .font_a_map, .font_b_map,
    .glyph_base, .fg_intense, .pan_value, .pan_shift
  );

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic close_out;
    $display("miscompares %0d checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : io_w

  task automatic reg_w(input logic [2:0] i, input logic [7:0] d);
    io_w(IO_SEQ_INDEX, {5'h00, i});
    io_w(IO_SEQ_DATA, d);
  endtask : reg_w

  task automatic reg_r(input logic [2:0] i, input logic [7:0] e);
    io_w(IO_SEQ_INDEX, {5'h00, i});
    @(negedge clk);
    io_addr = IO_SEQ_DATA;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    chk({8'h00, io_rdata}, {8'h00, e}, "register read");
  endtask : reg_r

  // Counts clocks and loads over n characters, starting at a boundary
  task automatic count_chars(input int n);
    int t;
    t = 0;
    loads = 0;
    cyc = 0;
    while (char_clk !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    repeat (n) begin
      do begin
        @(negedge clk);
        cyc++;
      end while (char_clk !== 1'b1 && cyc < 400);
      if (shift_load === 1'b1) loads++;
    end
  endtask : count_chars

  function automatic logic [3:0] pan_exp(input logic eight, input logic [3:0] p);
    if (eight) return {1'b0, p[2:0]};
    return (p > 4'h7) ? 4'h0 : p + 4'h1;
  endfunction : pan_exp

  task automatic font_check(input logic [7:0] v, input logic at, input logic ext);
    logic [2:0] a, b;
    a = {v[4], ext ? v[1:0] : 2'h0};
    b = {v[5], ext ? v[3:2] : 2'h0};
    chk({13'h0000, font_a_map}, {13'h0000, a}, "primary map");
    chk({13'h0000, font_b_map}, {13'h0000, b}, "secondary map");
    chk({15'h0000, fg_intense}, {15'h0000, at & (a == b)}, "intensity");
    chk(glyph_base, at ? {a[1:0], a[2], 13'h0000} : {b[1:0], b[2], 13'h0000}, "glyph");
  endtask : font_check

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    resetn = 1'b0;
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    nine_dot_disable = 1'b0;
    cpu_wr = 1'b0;
    cpu_plane_sel = 4'h0;
    attr_bit3 = 1'b0;
    pan_value = 4'h0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    reg_r(IDX_CLOCKING, RST_CLOCKING);
    reg_r(IDX_PLANE_MASK, RST_PLANE_MASK);
    reg_r(IDX_FONT_SEL, RST_FONT_SEL);
    reg_w(IDX_CLOCKING, 8'hFF);
    reg_w(IDX_PLANE_MASK, 8'hFF);
    reg_w(IDX_FONT_SEL, 8'hFF);
    reg_w(3'h0, 8'hFF);
    reg_r(IDX_CLOCKING, 8'h3D);
    reg_r(IDX_PLANE_MASK, 8'h0F);
    reg_r(IDX_FONT_SEL, 8'h3F);
    reg_r(3'h0, 8'h00);
    reg_r(3'h7, 8'h00);
    chk({15'h0000, screen_off}, 16'h0001, "screen off");
    reg_w(IDX_PLANE_MASK, 8'h05);
    for (int m = 0; m < 4; m++) begin
      reg_w(IDX_MEM_LAYOUT, 8'(m * 4));
      @(negedge clk);
      cpu_wr = 1'b1;
      cpu_plane_sel = 4'hF;
      @(negedge clk);
      chk({12'h000, plane_wr_en}, 16'h0005, "plane enables");
      chk({14'h0000, odd_even_mode, chain4_mode}, {14'h0000, m == 1, m >= 2}, "layout");
      cpu_wr = 1'b0;
      @(negedge clk);
      chk({12'h000, plane_wr_en}, 16'h0000, "plane idle");
    end
    foreach (clk_vals[k]) begin
      reg_w(IDX_CLOCKING, clk_vals[k]);
      count_chars(2);
      count_chars(8);
      chk(16'(cyc), 16'(len_exp[k] * 8), "char length");
      chk(16'(loads), 16'(load_exp[k]), "load cadence");
      chk({15'h0000, wide_char}, {15'h0000, ~clk_vals[k][0]}, "width flag");
    end
    reg_w(IDX_CLOCKING, 8'h00);
    nine_dot_disable = 1'b1;
    count_chars(2);
    count_chars(4);
    chk(16'(cyc), 16'h0020, "narrow override");
    chk({15'h0000, wide_char}, 16'h0000, "narrow flag");
    for (int m = 0; m < 2; m++) begin
      reg_w(IDX_CLOCKING, {7'h00, m[0]});
      foreach (pans[k]) begin
        @(negedge clk);
        pan_value = pans[k];
        repeat (2) @(negedge clk);
        chk({12'h000, pan_shift}, {12'h000, pan_exp(m[0], pans[k])}, "pan");
      end
      nine_dot_disable = 1'b0;
    end
    reg_w(IDX_MEM_LAYOUT, 8'h02);
    foreach (fonts[k]) begin
      reg_w(IDX_FONT_SEL, fonts[k]);
      for (int a = 0; a < 2; a++) begin
        @(negedge clk);
        attr_bit3 = a[0];
        repeat (2) @(negedge clk);
        font_check(fonts[k], a[0], 1'b1);
      end
    end
    reg_w(IDX_FONT_SEL, 8'h2D);
    reg_w(IDX_MEM_LAYOUT, 8'h00);
    attr_bit3 = 1'b0;
    repeat (2) @(negedge clk);
    font_check(8'h2D, 1'b0, 1'b0);
    // Mid-run reset must bring the registers back to their defaults
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    reg_r(IDX_FONT_SEL, RST_FONT_SEL);
    reg_r(IDX_CLOCKING, RST_CLOCKING);
    chk({15'h0000, screen_off}, 16'h0000, "screen on after reset");
    close_out();
  end
endmodule : tb_vscf_sequencer
